// [hsp_cfg.svh]
// Constants for the host serial port with start-up rate and format detection
`ifndef HSP_CFG_SVH
`define HSP_CFG_SVH

`define HSP_CLK_HZ 20000000
`define HSP_BAUD0 9600
`define HSP_BAUD1 19200
`define HSP_BAUD2 38400
`define HSP_BAUD3 57600
`define HSP_BAUD4 115200
`define HSP_BAUD5 230400
`define HSP_BAUD6 460800
`define HSP_BAUD7 921600
`define HSP_BAUD8 3000000
`define HSP_BAUD9 3250000
`define HSP_BAUD10 6000000
`define HSP_BAUD11 6500000
`define HSP_PER(b) (12'((`HSP_CLK_HZ + (b) / 2) / (b)))
`define HSP_RATE_NUM 4'hc
`define HSP_RATE_DEF 4'h4

`define HSP_FMT_8N2 3'h0
`define HSP_FMT_8N1 3'h1
`define HSP_FMT_8E1 3'h2
`define HSP_FMT_8O1 3'h3
`define HSP_FMT_7E1 3'h4
`define HSP_FMT_7O1 3'h5
`define HSP_FMT_NUM 3'h6

`define HSP_FLOW_HW 2'h0
`define HSP_FLOW_SW 2'h1
`define HSP_PSV_RTS 2'h1
`define HSP_PSV_DTR 2'h2
`define HSP_XON 8'h11
`define HSP_XOFF 8'h13

`define HSP_ADDR_CTRL 3'h0
`define HSP_ADDR_CFG 3'h1
`define HSP_ADDR_TXD 3'h2
`define HSP_ADDR_RXD 3'h3
`define HSP_ADDR_STAT 3'h4
`define HSP_ADDR_MODEM 3'h5
`define HSP_CTRL_RST 5'h10
`define HSP_CTRL_AUTO 4
`define HSP_CFG_FMT_LSB 4

`endif

// [hsp_pkg.sv]
// Types for the host serial port
package hsp_pkg;
	typedef enum logic [4:0]
	{
		RX_IDLE  = 5'h01,
		RX_START = 5'h02,
		RX_DATA  = 5'h04,
		RX_PAR   = 5'h08,
		RX_STOP  = 5'h10
	} hsp_rx_state_type;
	typedef enum logic [4:0]
	{
		TX_IDLE  = 5'h01,
		TX_START = 5'h02,
		TX_DATA  = 5'h04,
		TX_PAR   = 5'h08,
		TX_STOP  = 5'h10
	} hsp_tx_state_type;
	typedef enum logic [3:0]
	{
		DET_WAIT = 4'h1,
		DET_MEAS = 4'h2,
		DET_SAMP = 4'h4,
		DET_DONE = 4'h8
	} hsp_det_state_type;
endpackage

// [hsp_serial_port.sv]
// Host serial port: UART, flow control, modem lines, start-up detection
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "hsp_cfg.svh"
module hsp_serial_port
	import hsp_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic [2:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	input  wire logic       txd,
	input  wire logic       rtsN,
	input  wire logic       dtrN,
	output logic            rxd,
	output logic            ctsN,
	output logic            dsrN,
	output logic            dcdN,
	output logic            riN
);

////////////////////////////////////////////////////////////////////////////////

function automatic logic [11:0] hspPer(input logic [3:0] i);
	case (i)
		4'h0: return `HSP_PER(`HSP_BAUD0);
		4'h1: return `HSP_PER(`HSP_BAUD1);
		4'h2: return `HSP_PER(`HSP_BAUD2);
		4'h3: return `HSP_PER(`HSP_BAUD3);
		4'h4: return `HSP_PER(`HSP_BAUD4);
		4'h5: return `HSP_PER(`HSP_BAUD5);
		4'h6: return `HSP_PER(`HSP_BAUD6);
		4'h7: return `HSP_PER(`HSP_BAUD7);
		4'h8: return `HSP_PER(`HSP_BAUD8);
		4'h9: return `HSP_PER(`HSP_BAUD9);
		4'ha: return `HSP_PER(`HSP_BAUD10);
		4'hb: return `HSP_PER(`HSP_BAUD11);
		default: return `HSP_PER(`HSP_BAUD4);
	endcase
endfunction

// Rate whose bit time lies closest to a measured start bit
function automatic logic [3:0] hspNearest(input logic [11:0] m);
	logic [3:0]  best;
	logic [12:0] bd;
	logic [12:0] d;
	logic [11:0] p;
	best = `HSP_RATE_DEF;
	bd = 13'h1fff;
	for (int i = 0; i < 12; i++)
	begin
		p = hspPer(4'(i));
		d = (m > p) ? 13'(m - p) : 13'(p - m);
		if (d < bd)
		begin
			bd = d;
			best = 4'(i);
		end
	end
	return best;
endfunction

////////////////////////////////////////////////////////////////////////////////

logic [2:0] syncA;
logic [2:0] syncB;
logic [4:0] ctrl;
logic [3:0] rate;
logic [2:0] fmt;
logic [2:0] modem;
logic       xoff;

hsp_det_state_type detSt;
logic [11:0]       detCnt;
logic [8:0]        detBits;
logic [3:0]        detIdx;

hsp_rx_state_type rxSt;
logic [11:0]      rxCnt;
logic [2:0]       rxBit;
logic [7:0]       rxSh;
logic             rxPar;
logic [7:0]       rxBuf;
logic             rxValid;
logic             parErr;
logic             frmErr;
logic             ovr;

hsp_tx_state_type txSt;
logic [11:0]      txCnt;
logic [2:0]       txBit;
logic [7:0]       txSh;
logic [7:0]       txHold;
logic             txPend;
logic             txStop2;

// two-stage sync of the three inputs
always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		syncA <= 3'h7;
		syncB <= 3'h7;
	end
	else
	begin
		syncA <= {txd, rtsN, dtrN};
		syncB <= syncA;
	end

wire txdS   = syncB[2];
wire rtsOff = syncB[1];
wire dtrOff = syncB[0];

wire [1:0]  flow    = ctrl[1:0];
wire [1:0]  psvSel  = ctrl[3:2];
wire        autoEn  = ctrl[`HSP_CTRL_AUTO];
wire [11:0] bitPer  = hspPer(rate);
wire [11:0] halfPer = {1'b0, bitPer[11:1]};
wire        detDone = (detSt == DET_DONE);

wire       fmt7   = (fmt == `HSP_FMT_7E1) || (fmt == `HSP_FMT_7O1);
wire       parOn  = (fmt != `HSP_FMT_8N2) && (fmt != `HSP_FMT_8N1);
wire       parOdd = (fmt == `HSP_FMT_8O1) || (fmt == `HSP_FMT_7O1);
wire       stop2  = (fmt == `HSP_FMT_8N2);
wire [2:0] lastBit = fmt7 ? 3'h6 : 3'h7;

// Register decode
wire wrCtrl  = regWr && (regAddr == `HSP_ADDR_CTRL);
wire wrCfg   = regWr && (regAddr == `HSP_ADDR_CFG);
wire wrTx    = regWr && (regAddr == `HSP_ADDR_TXD);
wire wrStat  = regWr && (regAddr == `HSP_ADDR_STAT);
wire wrModem = regWr && (regAddr == `HSP_ADDR_MODEM);
wire rdRx    = regRd && (regAddr == `HSP_ADDR_RXD);
wire [3:0] cfgRate = regWdata[3:0];
wire [2:0] cfgFmt  = regWdata[`HSP_CFG_FMT_LSB +: 3];

// power saving follows RTS or DTR only when selected
wire psvActive = ((psvSel == `HSP_PSV_RTS) && rtsOff) ||
                 ((psvSel == `HSP_PSV_DTR) && dtrOff);
wire txBusy = txPend || (txSt != TX_IDLE);

////////////////////////////////////////////////////////////////////////////////

always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		ctrl  <= `HSP_CTRL_RST;
		modem <= 3'h0;
	end
	else
	begin
		if (wrCtrl)
			ctrl <= regWdata[4:0];
		if (wrModem)
			modem <= regWdata[2:0];
	end

// Start-up detection: time the first start bit, then sample the character
always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		detSt   <= DET_WAIT;
		detCnt  <= 12'h000;
		detBits <= 9'h000;
		detIdx  <= 4'h0;
	end
	else
	begin
		case (detSt)
			DET_WAIT:
				if (!autoEn)
					detSt <= DET_DONE;
				else if (!txdS)
				begin
					detSt  <= DET_MEAS;
					detCnt <= 12'h001;
				end
			DET_MEAS:
				if (!autoEn)
					detSt <= DET_DONE;
				else if (txdS)
				begin
					detSt  <= DET_SAMP;
					detCnt <= hspPer(hspNearest(detCnt)) >> 1;
					detIdx <= 4'h0;
				end
				else if (detCnt != 12'hfff)
					detCnt <= detCnt + 12'h001;
			DET_SAMP:
				if (detCnt != 12'h000)
					detCnt <= detCnt - 12'h001;
				else
				begin
					detBits <= {txdS, detBits[8:1]};
					detCnt  <= bitPer - 12'h001;
					detIdx  <= detIdx + 4'h1;
					if (detIdx == 4'h8)
						detSt <= DET_DONE;
				end
			DET_DONE:
				detSt <= DET_DONE;
			default:
				detSt <= DET_DONE;
		endcase
	end

always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		rate <= `HSP_RATE_DEF;
		fmt  <= `HSP_FMT_8N1;
	end
	else
	begin
		if ((detSt == DET_MEAS) && autoEn && txdS)
			rate <= hspNearest(detCnt);
		// format from the sampled first character
		if ((detSt == DET_SAMP) && (detCnt == 12'h000) && (detIdx == 4'h8))
			fmt <= detBits[8] ? `HSP_FMT_7O1 :
			       (!txdS ? `HSP_FMT_8E1 : `HSP_FMT_8N1);
		if (wrCfg && (cfgRate < `HSP_RATE_NUM))
			rate <= cfgRate;
		if (wrCfg && (cfgFmt < `HSP_FMT_NUM))
			fmt <= cfgFmt;
	end

////////////////////////////////////////////////////////////////////////////////

wire       rxTick = (rxCnt == 12'h000);
wire [7:0] rxByte = fmt7 ? {1'b0, rxSh[7:1]} : rxSh;
wire       rxEnd  = (rxSt == RX_STOP) && rxTick;
wire       rxFlow = (flow == `HSP_FLOW_SW) &&
                    ((rxByte == `HSP_XON) || (rxByte == `HSP_XOFF));

// receive: start, data LSB first, parity, stop
always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		rxSt  <= RX_IDLE;
		rxCnt <= 12'h000;
		rxBit <= 3'h0;
		rxSh  <= 8'h00;
		rxPar <= 1'b0;
	end
	else
	begin
		if (!rxTick)
			rxCnt <= rxCnt - 12'h001;
		case (rxSt)
			RX_IDLE:
				if (detDone && !txdS)
				begin
					rxSt  <= RX_START;
					rxCnt <= halfPer;
				end
			RX_START:
				if (rxTick)
				begin
					rxSt  <= txdS ? RX_IDLE : RX_DATA;
					rxCnt <= bitPer - 12'h001;
					rxBit <= 3'h0;
					rxPar <= 1'b0;
				end
			RX_DATA:
				if (rxTick)
				begin
					rxSh  <= {txdS, rxSh[7:1]};
					rxPar <= rxPar ^ txdS;
					rxBit <= rxBit + 3'h1;
					rxCnt <= bitPer - 12'h001;
					if (rxBit == lastBit)
						rxSt <= parOn ? RX_PAR : RX_STOP;
				end
			RX_PAR:
				if (rxTick)
				begin
					rxPar <= rxPar ^ txdS;
					rxCnt <= bitPer - 12'h001;
					rxSt  <= RX_STOP;
				end
			RX_STOP:
				if (rxTick)
					rxSt <= RX_IDLE;
			default:
				rxSt <= RX_IDLE;
		endcase
	end

// Received byte and sticky errors; a new event wins over its clear
always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		rxBuf   <= 8'h00;
		rxValid <= 1'b0;
		parErr  <= 1'b0;
		frmErr  <= 1'b0;
		ovr     <= 1'b0;
		xoff    <= 1'b0;
	end
	else
	begin
		if (rdRx)
			rxValid <= 1'b0;
		if (wrStat)
		begin
			parErr <= parErr & ~regWdata[0];
			frmErr <= frmErr & ~regWdata[1];
			ovr    <= ovr & ~regWdata[2];
		end
		if ((rxSt == RX_PAR) && rxTick && ((rxPar ^ txdS) != parOdd))
			parErr <= 1'b1;
		if (rxEnd && !txdS)
			frmErr <= 1'b1;
		if (flow != `HSP_FLOW_SW)
			xoff <= 1'b0;
		else if (rxEnd && rxFlow)
			xoff <= (rxByte == `HSP_XOFF);
		if (rxEnd && !rxFlow)
		begin
			rxBuf   <= rxByte;
			rxValid <= 1'b1;
			// a host ignoring CTS overruns the buffer
			if (rxValid && !rdRx)
				ovr <= 1'b1;
		end
	end

////////////////////////////////////////////////////////////////////////////////

wire txTick  = (txCnt == 12'h000);
wire txAllow = detDone && !((flow == `HSP_FLOW_HW) && rtsOff) &&
               !((flow == `HSP_FLOW_SW) && xoff);
wire txParBit = (^(fmt7 ? {1'b0, txHold[6:0]} : txHold)) ^ parOdd;

// Holding register for one outgoing byte
always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		txHold <= 8'h00;
		txPend <= 1'b0;
	end
	else if (wrTx && !txBusy)
	begin
		txHold <= regWdata;
		txPend <= 1'b1;
	end
	else if ((txSt == TX_IDLE) && txAllow)
		txPend <= 1'b0;

// idle and stop high, start low on the data output
always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		txSt    <= TX_IDLE;
		txCnt   <= 12'h000;
		txBit   <= 3'h0;
		txSh    <= 8'h00;
		txStop2 <= 1'b0;
		rxd     <= 1'b1;
	end
	else
	begin
		if (!txTick)
			txCnt <= txCnt - 12'h001;
		case (txSt)
			TX_IDLE:
				if (txPend && txAllow)
				begin
					txSt  <= TX_START;
					txSh  <= txHold;
					txCnt <= bitPer - 12'h001;
					rxd   <= 1'b0;
				end
			TX_START:
				if (txTick)
				begin
					txSt  <= TX_DATA;
					txBit <= 3'h0;
					txCnt <= bitPer - 12'h001;
					rxd   <= txSh[0];
					txSh  <= {1'b0, txSh[7:1]};
				end
			TX_DATA:
				if (txTick)
				begin
					txCnt <= bitPer - 12'h001;
					txBit <= txBit + 3'h1;
					txStop2 <= stop2;
					if (txBit == lastBit)
					begin
						txSt <= parOn ? TX_PAR : TX_STOP;
						rxd  <= parOn ? txParBit : 1'b1;
					end
					else
					begin
						rxd  <= txSh[0];
						txSh <= {1'b0, txSh[7:1]};
					end
				end
			TX_PAR:
				if (txTick)
				begin
					txSt  <= TX_STOP;
					txCnt <= bitPer - 12'h001;
					rxd   <= 1'b1;
				end
			TX_STOP:
				if (txTick)
				begin
					txCnt   <= bitPer - 12'h001;
					txStop2 <= 1'b0;
					if (!txStop2)
						txSt <= TX_IDLE;
				end
			default:
				txSt <= TX_IDLE;
		endcase
	end

////////////////////////////////////////////////////////////////////////////////

wire [7:0] rdMux =
	(regAddr == `HSP_ADDR_CTRL)  ? {3'h0, ctrl} :
	(regAddr == `HSP_ADDR_CFG)   ? {1'b0, fmt, rate} :
	(regAddr == `HSP_ADDR_RXD)   ? rxBuf :
	(regAddr == `HSP_ADDR_STAT)  ? {1'b0, ovr, frmErr, parErr, psvActive,
	                                detDone, rxValid, txBusy} :
	(regAddr == `HSP_ADDR_MODEM) ? {xoff, 2'h0, rtsOff, dtrOff, modem} :
	8'h00;

// CTS OFF while full or power saving
always_ff @(posedge core_clk or negedge arst_n)
	if (!arst_n)
	begin
		regRdata <= 8'h00;
		ctsN     <= 1'b1;
		dsrN     <= 1'b1;
		dcdN     <= 1'b1;
		riN      <= 1'b1;
	end
	else
	begin
		regRdata <= regRd ? rdMux : 8'h00;
		ctsN     <= rxValid || psvActive;
		dsrN     <= ~modem[0];
		dcdN     <= ~modem[1];
		riN      <= ~modem[2];
	end

endmodule

// [hsp_serial_port_monitor.sv]
// Concurrent checks on the host serial port pins
`timescale 1ns/1ps
`include "hsp_cfg.svh"
module hsp_serial_port_monitor
(
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	input wire logic       txd,
	input wire logic       rtsN,
	input wire logic       dtrN,
	input wire logic       rxd,
	input wire logic       ctsN,
	input wire logic       dsrN,
	input wire logic       dcdN,
	input wire logic       riN
);
	wire modemWr = regWr && regAddr == `HSP_ADDR_MODEM;
	wire cfgRd = regRd && regAddr == `HSP_ADDR_CFG;
	logic [1:0] flowSeen;
	// Flow mode as last written: RTS only holds the sender in hardware mode
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			flowSeen <= `HSP_FLOW_HW;
		else if (regWr && regAddr == `HSP_ADDR_CTRL)
			flowSeen <= regWdata[1:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	AST_RDATA_IDLE: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data not zero outside read cycle");
	AST_MODEM_SET: assert property (modemWr |-> ##3 {riN, dcdN, dsrN} == ~$past(regWdata[2:0], 3))
		else $error("modem lines do not follow written ON bits");
	AST_MODEM_CAUSE: assert property ($changed({riN, dcdN, dsrN}) |-> $past(modemWr) || $past(modemWr, 2) || $past(modemWr, 3))
		else $error("modem line moved without a write");
	AST_LOW_BIT: assert property ($fell(rxd) |-> (!rxd)[*3])
		else $error("low bit on rxd shorter than fastest bit time");
	AST_HIGH_BIT: assert property ($rose(rxd) |-> rxd[*3])
		else $error("high bit on rxd shorter than fastest bit time");
	AST_HOLD_RTS: assert property (flowSeen == `HSP_FLOW_HW && rtsN && $past(rtsN)
		&& $past(rtsN, 2) && $past(rtsN, 3) && $past(rtsN, 4) && $past(rtsN, 5) |-> !$fell(rxd))
		else $error("character started while host RTS is OFF");
	AST_RATE_SET: assert property ($past(cfgRd) |-> regRdata[3:0] < 4'hc)
		else $error("unsupported rate index reported");
	AST_FMT_SET: assert property ($past(cfgRd) |-> regRdata[6:4] < 3'h6 && !regRdata[7])
		else $error("unsupported frame format reported");
endmodule

// [hsp_host_model.sv]
// Host terminal model: drives TXD, watches RXD and CTS
`timescale 1ns/1ps
module hsp_host_model
(
	input  wire logic core_clk,
	input  wire logic rxd,
	input  wire logic ctsN,
	output logic      txd
);
	initial txd = 1'b1;
	// frame bits go out LSB first, one bit time each
	task automatic send_char(input logic [11:0] frame, input int nb, input int per);
		int i;
		i = 0;
		// no character while CTS is OFF, unless CTS stays OFF for 5000 cycles
		while (ctsN !== 1'b0 && i < 5000)
		begin
			@(posedge core_clk);
			i++;
		end
		for (i = 0; i < nb; i++)
		begin
			@(posedge core_clk);
			txd <= frame[i];
			repeat (per - 1) @(posedge core_clk);
		end
	endtask
	// samples each bit in its middle
	task automatic recv_char(input int per, input int nb, output logic [11:0] bits);
		int i;
		bits = 12'h000;
		i = 0;
		while (rxd !== 1'b0 && i < 5000)
		begin
			@(posedge core_clk);
			i++;
		end
		repeat (per / 2) @(posedge core_clk);
		for (i = 0; i < nb; i++)
		begin
			bits[i] = rxd;
			repeat (per) @(posedge core_clk);
		end
	endtask
endmodule

// [hsp_serial_port_tb.sv]
// Self-checking bench for the host serial port
`timescale 1ns/1ps
`include "hsp_cfg.svh"
module hsp_serial_port_tb
	import hsp_pkg::*;
;
	logic        core_clk;
	logic        arst_n;
	logic [2:0]  regAddr;
	logic [7:0]  regWdata;
	logic        regWr;
	logic        regRd;
	logic [7:0]  regRdata;
	logic        txd;
	logic        rtsN;
	logic        dtrN;
	logic        rxd;
	logic        ctsN;
	logic        dsrN;
	logic        dcdN;
	logic        riN;
	logic [7:0]  v;
	logic [7:0]  d;
	logic [11:0] b;
	logic [31:0] seed;
	int          fails;
	int          n_compared;
	int          k;
	int          p7;
	int          p8;

	hsp_serial_port hsp_serial_port_inst (.core_clk, .arst_n, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .txd, .rtsN, .dtrN, .rxd, .ctsN, .dsrN, .dcdN, .riN);
	hsp_host_model hsp_host_model_inst (.core_clk, .rxd, .ctsN, .txd);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			fails++;
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] w);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= w;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] r);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 r = regRdata;
	endtask
	task automatic test_done();
		if (fails == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		test_done();
	end
	initial
	begin
		{arst_n, regAddr, regWdata, regWr, regRd, rtsN, dtrN} = 16'h0;
		fails = 0;
		n_compared = 0;
		seed = 32'h5bf79383;
		p7 = `HSP_PER(`HSP_BAUD7);
		p8 = `HSP_PER(`HSP_BAUD8);
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		#1 check("idle", {5'h0, rxd, dcdN, dsrN}, 8'h07);
		rd(`HSP_ADDR_CTRL, v);
		check("ctrl", v, 8'h10);
		rd(`HSP_ADDR_CFG, v);
		check("cfgdef", v, 8'h14);
		hsp_host_model_inst.send_char({3'b111, 8'h41, 1'b0}, 10, p7);
		repeat (3 * p7) @(posedge core_clk);
		rd(`HSP_ADDR_STAT, v);
		check("stat", {5'h0, v[2:0]}, 8'h04);
		rd(`HSP_ADDR_CFG, v);
		check("cfgdet", v, 8'h17);
		for (k = 0; k < 3; k++)
		begin
			seed = xs(seed);
			d = (k == 0) ? 8'h11 : seed[7:0];
			hsp_host_model_inst.send_char({3'b111, d, 1'b0}, 10, p7);
			repeat (3) @(posedge core_clk);
			check("ctsfull", {7'h0, ctsN}, 8'h01);
			rd(`HSP_ADDR_RXD, v);
			check("rxbyte", v, d);
			repeat (3) @(posedge core_clk);
			check("ctsfree", {7'h0, ctsN}, 8'h00);
		end
		rd(`HSP_ADDR_CFG, v);
		check("cfgkeep", v, 8'h17);
		wr(`HSP_ADDR_CFG, 8'h28);
		rd(`HSP_ADDR_CFG, v);
		check("cfgcmd", v, 8'h28);
		wr(`HSP_ADDR_CFG, 8'h7f);
		rd(`HSP_ADDR_CFG, v);
		check("cfgbad", v, 8'h28);
		rtsN <= 1'b1;
		repeat (8) @(posedge core_clk);
		seed = xs(seed);
		d = seed[7:0];
		wr(`HSP_ADDR_TXD, d);
		repeat (40) @(posedge core_clk);
		check("txheld", {7'h0, rxd}, 8'h01);
		rtsN <= 1'b0;
		hsp_host_model_inst.recv_char(p8, 11, b);
		check("txdata", b[8:1], d);
		check("txframe", {5'h0, b[10:9], b[0]}, {5'h0, 1'b1, ^d, 1'b0});
		seed = xs(seed);
		d = seed[7:0];
		hsp_host_model_inst.send_char({2'b11, ^d, d, 1'b0}, 11, p8);
		repeat (3) @(posedge core_clk);
		rd(`HSP_ADDR_RXD, v);
		check("rxeven", v, d);
		seed = xs(seed);
		d = seed[7:0];
		hsp_host_model_inst.send_char({2'b11, ~^d, d, 1'b0}, 11, p8);
		repeat (3) @(posedge core_clk);
		rd(`HSP_ADDR_STAT, v);
		check("parerr", {7'h0, v[4]}, 8'h01);
		rd(`HSP_ADDR_RXD, v);
		wr(`HSP_ADDR_STAT, 8'h01);
		rd(`HSP_ADDR_STAT, v);
		check("parclr", {7'h0, v[4]}, 8'h00);
		for (k = 0; k < 6; k++)
		begin
			wr(`HSP_ADDR_CTRL, {4'h0, 2'(k / 2), 2'h0});
			rtsN <= k[0];
			dtrN <= ~k[0];
			repeat (5) @(posedge core_clk);
			check("ctspsv", {7'h0, ctsN}, {7'h0, (k / 2 == 1 && k[0]) || (k / 2 == 2 && !k[0])});
		end
		wr(`HSP_ADDR_MODEM, 8'h05);
		repeat (4) @(posedge core_clk);
		check("modem", {5'h0, riN, dcdN, dsrN}, 8'h02);
		rd(`HSP_ADDR_MODEM, v);
		check("modemrd", v, 8'h15);
		rd(3'h6, v);
		check("unmapped", v, 8'h00);
		wr(`HSP_ADDR_CFG, 8'h58);
		seed = xs(seed);
		d = {1'b0, seed[6:0]};
		hsp_host_model_inst.send_char({3'b111, ~^d, d[6:0], 1'b0}, 10, p8);
		repeat (3) @(posedge core_clk);
		rd(`HSP_ADDR_RXD, v);
		check("rx7o1", v, d);
		wr(`HSP_ADDR_CTRL, 8'h01);
		hsp_host_model_inst.send_char({3'b111, ~^7'h13, 7'h13, 1'b0}, 10, p8);
		repeat (3) @(posedge core_clk);
		rd(`HSP_ADDR_MODEM, v);
		check("xoff", {7'h0, v[7]}, 8'h01);
		seed = xs(seed);
		d = seed[7:0];
		wr(`HSP_ADDR_TXD, d);
		repeat (30) @(posedge core_clk);
		check("swheld", {7'h0, rxd}, 8'h01);
		hsp_host_model_inst.send_char({3'b111, ~^7'h11, 7'h11, 1'b0}, 10, p8);
		hsp_host_model_inst.recv_char(p8, 10, b);
		check("tx7o1", {1'b0, b[7:1]}, {1'b0, d[6:0]});
		check("txpar", {5'h0, b[9:8], b[0]}, {5'h0, 1'b1, ~^d[6:0], 1'b0});
		test_done();
	end
endmodule

bind hsp_serial_port hsp_serial_port_monitor hsp_serial_port_monitor_inst (.core_clk, .arst_n,
	.regAddr, .regWdata, .regWr, .regRd, .regRdata, .txd, .rtsN, .dtrN, .rxd, .ctsN, .dsrN,
	.dcdN, .riN);
